//--- design/imo_regs.svh
`ifndef IMO_REGS_SVH
`define IMO_REGS_SVH

// ==========================================================
// Sizes
// ==========================================================
`define IMO_LINES 8
`define IMO_PINS 20
`define IMO_VEC_DEPTH 16

// ==========================================================
// Reset values
// ==========================================================
`define IMO_ZERO8 8'h00
`define IMO_MASK_RST 8'hFF
`define IMO_LAST_RST 3'h7
`define IMO_ZERO3 3'h0

// ==========================================================
// Readback codes held in the mode register's select field
// ==========================================================
`define IMO_RB_PEND 2'h0
`define IMO_RB_ISR 2'h1
`define IMO_RB_MASK 2'h2
`define IMO_RB_ACR 2'h3

// ==========================================================
// Group numbers and pin field positions
// ==========================================================
`define IMO_GRP_ONE 1'b0
`define IMO_GRP_TWO 1'b1
`define IMO_PIO_LOW 11:0
`define IMO_PIO_HIGH 15:12
// Positions inside the synchronised pin word
`define IMO_G1_BITS 7:0
`define IMO_G2_LOW 11:8
`define IMO_UR_BITS 19:16
// Shared arm bit inside a mode write
`define IMO_ARM_BIT 7

`endif

//--- design/imo_pkg.sv
package imo_pkg;

`include "imo_regs.svh"

    // ==========================================================
    // Mode register layout, bit 7 down to bit 0
    // ==========================================================
    typedef struct packed {
        logic global_arm_bit;             // Arm bit, shared by both groups
        logic readback_select_high;       // Readback code, upper bit
        logic readback_select_low;        // Readback code, lower bit
        logic request_edge_polarity_bit;  // 1 = rising edge active
        logic unused_zero;                // Software keeps this at 0
        logic poll_select_bit;            // 1 = polled operation
        logic vector_sharing_bit;         // 1 = common vector
        logic priority_scheme_bit;        // 1 = rotating priority
    } group_mode_control_t;

    // ==========================================================
    // Host command strobes, one cycle each
    // ==========================================================
    typedef struct packed {
        logic wr_mode;     // Load group_mode_control
        logic wr_mask;     // Load mask_bits
        logic wr_acr;      // Load auto_clear_bits
        logic wr_vec;      // Load one vector memory location
        logic clr_isr;     // Clear one in_service_bits entry
        logic clr_pend;    // Clear one pending_latch entry
        logic grp;         // Target group
        logic [2:0] line;  // Target line
        logic [7:0] data;  // Write data
    } host_cmd_t;

    // Result of one priority search
    typedef struct packed {
        logic found;       // Some candidate exists
        logic [2:0] idx;   // Winning line
    } pick_t;

    // ==========================================================
    // Helper functions
    // ==========================================================

    // Circular search starting at a given line; start 0 is fixed order
    function automatic pick_t pick_line(input logic [7:0] req, input logic [2:0] start);
        pick_t p;
        logic [2:0] j;
        p = '0;
        j = start;
        for (int k = 0; k < `IMO_LINES; k++)
        begin
            j = 3'(start + 3'(k));
            if (!p.found && req[j])
            begin
                p.found = 1'b1;
                p.idx = j;
            end
        end
        return p;
    endfunction

    // Lines strictly above the highest in-service line may pass the fence
    function automatic logic [7:0] fixed_fence(input logic [7:0] in_service_bits);
        logic [7:0] m;
        m = `IMO_MASK_RST;
        for (int i = `IMO_LINES - 1; i >= 0; i--)
        begin
            if (in_service_bits[i])
            begin
                m = 8'(`IMO_MASK_RST >> (`IMO_LINES - i));
            end
        end
        return m;
    endfunction

    // One-hot of a line number
    function automatic logic [7:0] line_bit(input logic [2:0] idx);
        return 8'(1) << idx;
    endfunction

endpackage

//--- design/interrupt_mode_options.sv
// Functional notes
// - Priority bit 0 gives fixed position-based priority
// - Group one line 0 highest, group two 7 lowest
// - Jumper picks user reply or parallel bits 15:12
// - Arbitrate at acknowledge, then drive chosen vector
// - Priority bit 1 selects rotating, same start order
// - Last serviced line goes lowest in circle
// - Rotation within group; group one always first
// - New rotation applies when in-service bit clears, or at acknowledge if auto-cleared
// - Rotating: any in-service bit blocks new requests
// - Sharing bit 0: each line own vector
// - Sharing bit 1: always line 0 vector
// - Poll bit 0: requests reach group and bus
// - Poll bit 1: group request held inactive
// - Polled: no in-service, fence, or auto pending clear
// - Polarity 0: falling edge sets pending
// - Polarity 1: rising edge sets pending
// - Mode bits 5,6 choose read source only
// - Readback choice persists until rewritten
// - Arm bit is global, others per group
// - Disarmed: latch requests, forward none
// - Mask entry 0 enables, 1 disables
module interrupt_mode_options
    import imo_pkg::*;
(
    input wire logic CLK_I,                    // 50 MHz clock
    input wire logic RST_B_I,                  // Async reset, active low
    input wire logic CE_I,                     // Clock enable, freezes state
    input wire logic [15:0] PIO_I,             // Parallel request pins
    input wire logic [3:0] USER_REPLY_I,       // User reply request pins
    input wire logic SOURCE_SELECT_JUMPER_I,   // 1 = user reply lines feed group two
    input wire host_cmd_t HOST_CMD_I,          // Host command strobes
    input wire logic DP_RD_I,                  // Data port read strobe
    input wire logic DP_RD_GRP_I,              // Group of the data port read
    input wire logic ACKNOWLEDGE_STROBE_I,     // Host acknowledge, level
    output logic [1:0] GROUP_REQUEST_O,        // Per-group request out
    output logic BUS_REQUEST_LEVEL_FOUR_O,     // Bus interrupt request
    output logic [7:0] RD_DATA_O,              // Data port read value
    output logic [7:0] VECTOR_O,               // Vector for the acknowledge
    output logic VECTOR_VALID_O,               // One-cycle vector pulse
    output logic VECTOR_GRP_O                  // Group that won
);

`include "imo_regs.svh"

    // ==========================================================
    // State
    // ==========================================================
    logic [`IMO_PINS-1:0] meta_r; // First synchroniser stage
    logic [`IMO_PINS-1:0] sync_r; // Second synchroniser stage
    logic [`IMO_PINS-1:0] prev_r; // Previous synchronised level
    logic jmp_meta_r;                     // Jumper first stage
    logic jmp_sync_r;                     // Jumper second stage
    logic ack_prev_r;                     // Acknowledge history
    logic global_arm_r;                   // Shared arm bit
    group_mode_control_t mode_r [2];      // Per-group mode
    logic [7:0] pend_r [2];               // pending_latch
    logic [7:0] isr_r [2];                // in_service_bits
    logic [7:0] mask_r [2];               // mask_bits
    logic [7:0] acr_r [2];                // auto_clear_bits
    logic [2:0] last_r [2];               // Most recently serviced line
    logic [2:0] sel_r [2];                // Line currently in service
    logic [7:0] vec_mem [`IMO_VEC_DEPTH]; // Vector memory, 8 lines per group

    logic [7:0] lines [2];                // Synchronised group inputs
    logic [7:0] edge_v [2];               // Active transitions this cycle
    logic [7:0] cand [2];                 // Lines allowed to request
    pick_t pick [2];                      // Search result per group
    logic ack_rise;                       // Start of an acknowledge
    logic win_grp;                        // Group chosen at acknowledge
    pick_t win;                           // Line chosen at acknowledge

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Both reply sources are synchronised; the choice is made after
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            // Idle high level, so a pin resting high makes no edge at release
            meta_r <= '1;
            sync_r <= '1;
            prev_r <= '1;
            jmp_meta_r <= 1'b0;
            jmp_sync_r <= 1'b0;
        end
        else if (CE_I)
        begin
            meta_r <= {USER_REPLY_I, PIO_I[`IMO_PIO_HIGH], PIO_I[`IMO_PIO_LOW]};
            sync_r <= meta_r;
            prev_r <= sync_r;
            jmp_meta_r <= SOURCE_SELECT_JUMPER_I;
            jmp_sync_r <= jmp_meta_r;
        end
    end

    // Group two upper inputs come from one source or the other
    always_comb
    begin
        lines[0] = sync_r[`IMO_G1_BITS];
        lines[1] = jmp_sync_r ? {sync_r[`IMO_UR_BITS], sync_r[`IMO_G2_LOW]}
                              : {sync_r[`IMO_PIO_HIGH], sync_r[`IMO_G2_LOW]};
    end

    assign ack_rise = ACKNOWLEDGE_STROBE_I && !ack_prev_r;
    // Group one is searched first so it always wins over group two
    assign win_grp = pick[0].found ? `IMO_GRP_ONE : `IMO_GRP_TWO;
    assign win = pick[0].found ? pick[0] : pick[1];

    // ==========================================================
    // Per-group logic
    // ==========================================================
    for (genvar g = 0; g < 2; g++)
    begin : grp
        logic [7:0] prev_g;   // Previous level of this group's inputs
        logic [7:0] fence;    // Lines the in-service fence lets through
        logic [2:0] start;    // First line of the priority search
        logic hit;            // Host command aims at this group
        logic acked;          // Acknowledge selects this group
        logic [7:0] ack_bit;  // Line chosen at acknowledge
        logic [7:0] clr_bit;  // Line named by the host command

        assign prev_g = (g == 0) ? prev_r[`IMO_G1_BITS]
                      : (jmp_sync_r ? {prev_r[`IMO_UR_BITS], prev_r[`IMO_G2_LOW]}
                                    : {prev_r[`IMO_PIO_HIGH], prev_r[`IMO_G2_LOW]});
        // Edge direction follows the polarity bit
        assign edge_v[g] = mode_r[g].request_edge_polarity_bit
                         ? (lines[g] & ~prev_g)
                         : (~lines[g] & prev_g);
        assign hit = (HOST_CMD_I.grp == 1'(g));
        assign acked = ack_rise && win.found && (win_grp == 1'(g));
        assign ack_bit = line_bit(win.idx);
        assign clr_bit = line_bit(HOST_CMD_I.line);

        // Rotating: any in-service bit shuts all; fixed: that line and lower ones
        assign fence = mode_r[g].priority_scheme_bit
                     ? ((isr_r[g] == `IMO_ZERO8) ? `IMO_MASK_RST : `IMO_ZERO8)
                     : fixed_fence(isr_r[g]);
        // Start after the last serviced line when rotating, else at line 0
        assign start = mode_r[g].priority_scheme_bit ? 3'(last_r[g] + 3'h1)
                                                     : `IMO_ZERO3;
        // Masked, disarmed or polled lines never request
        assign cand[g] = pend_r[g] & ~mask_r[g] & {8{global_arm_r}}
                       & fence & {8{!mode_r[g].poll_select_bit}};
        assign pick[g] = pick_line(cand[g], start);

        // Mode, mask and auto-clear loads
        always_ff @(posedge CLK_I or negedge RST_B_I)
        begin
            if (!RST_B_I)
            begin
                mode_r[g] <= '0;
                mask_r[g] <= `IMO_MASK_RST;
                acr_r[g] <= `IMO_ZERO8;
            end
            else if (CE_I && hit)
            begin
                // Select field is kept until the next mode load
                if (HOST_CMD_I.wr_mode)
                    mode_r[g] <= group_mode_control_t'(HOST_CMD_I.data);
                if (HOST_CMD_I.wr_mask)
                    mask_r[g] <= HOST_CMD_I.data;
                if (HOST_CMD_I.wr_acr)
                    acr_r[g] <= HOST_CMD_I.data;
            end
        end

        // Pending latch: a new edge wins over any clear in the same cycle
        always_ff @(posedge CLK_I or negedge RST_B_I)
        begin
            if (!RST_B_I)
                pend_r[g] <= `IMO_ZERO8;
            else if (CE_I)
                pend_r[g] <= (pend_r[g]
                             & ~((hit && HOST_CMD_I.clr_pend) ? clr_bit : `IMO_ZERO8)
                             & ~(acked ? ack_bit : `IMO_ZERO8))
                             | edge_v[g];
        end

        // In-service bits and rotation point
        always_ff @(posedge CLK_I or negedge RST_B_I)
        begin
            if (!RST_B_I)
            begin
                isr_r[g] <= `IMO_ZERO8;
                last_r[g] <= `IMO_LAST_RST;
                sel_r[g] <= `IMO_ZERO3;
            end
            else if (CE_I)
            begin
                // Acknowledge can only occur in interrupt mode
                if (acked && !acr_r[g][win.idx])
                begin
                    isr_r[g] <= (isr_r[g] & ~((hit && HOST_CMD_I.clr_isr) ? clr_bit
                                                                            : `IMO_ZERO8))
                              | ack_bit;
                    sel_r[g] <= win.idx;
                end
                else
                begin
                    // Auto-clear: the bit never stands, rotation moves at once
                    if (acked)
                        last_r[g] <= win.idx;
                    if (hit && HOST_CMD_I.clr_isr)
                    begin
                        isr_r[g] <= isr_r[g] & ~clr_bit;
                        // Rotation only moves once the served line is released
                        if (HOST_CMD_I.line == sel_r[g] && isr_r[g][sel_r[g]])
                            last_r[g] <= sel_r[g];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Arm bit, vector memory and request outputs
    // ==========================================================
    // One arm bit for the whole block, loaded by either group
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            global_arm_r <= 1'b0;
        else if (CE_I && HOST_CMD_I.wr_mode)
            global_arm_r <= HOST_CMD_I.data[`IMO_ARM_BIT];
    end

    // Vector memory has no reset; software loads it before arming
    always_ff @(posedge CLK_I)
    begin
        if (CE_I && HOST_CMD_I.wr_vec)
            vec_mem[{HOST_CMD_I.grp, HOST_CMD_I.line}] <= HOST_CMD_I.data;
    end

    // Requests are registered so the bus sees clean levels
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            GROUP_REQUEST_O <= 2'h0;
            BUS_REQUEST_LEVEL_FOUR_O <= 1'b0;
            ack_prev_r <= 1'b0;
        end
        else if (CE_I)
        begin
            GROUP_REQUEST_O <= {|cand[1], |cand[0]};
            BUS_REQUEST_LEVEL_FOUR_O <= |cand[0] || |cand[1];
            ack_prev_r <= ACKNOWLEDGE_STROBE_I;
        end
    end

    // Selection happens only on the acknowledge edge
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            VECTOR_O <= `IMO_ZERO8;
            VECTOR_VALID_O <= 1'b0;
            VECTOR_GRP_O <= 1'b0;
        end
        else if (CE_I)
        begin
            VECTOR_VALID_O <= ack_rise && win.found;
            if (ack_rise && win.found)
            begin
                VECTOR_GRP_O <= win_grp;
                VECTOR_O <= mode_r[win_grp].vector_sharing_bit
                          ? vec_mem[{win_grp, `IMO_ZERO3}]
                          : vec_mem[{win_grp, win.idx}];
            end
        end
    end

    // Data port read; the select field never steers writes
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            RD_DATA_O <= `IMO_ZERO8;
        else if (CE_I && DP_RD_I)
        begin
            case ({mode_r[DP_RD_GRP_I].readback_select_high,
                   mode_r[DP_RD_GRP_I].readback_select_low})
                `IMO_RB_PEND: RD_DATA_O <= pend_r[DP_RD_GRP_I];
                `IMO_RB_ISR: RD_DATA_O <= isr_r[DP_RD_GRP_I];
                `IMO_RB_MASK: RD_DATA_O <= mask_r[DP_RD_GRP_I];
                `IMO_RB_ACR: RD_DATA_O <= acr_r[DP_RD_GRP_I];
                default: RD_DATA_O <= `IMO_ZERO8;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    a_poll_holds_quiet: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && mode_r[0].poll_select_bit) |=> !GROUP_REQUEST_O[0])
        else $error("polled group raised its request");
    a_disarm_no_bus: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && !global_arm_r) |=> !BUS_REQUEST_LEVEL_FOUR_O)
        else $error("bus request while disarmed");
    a_edge_sets_pend: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && edge_v[1] != `IMO_ZERO8) |=> ((pend_r[1] & $past(edge_v[1])) == $past(edge_v[1])))
        else $error("edge did not set pending");
    a_rot_fence_all: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && mode_r[0].priority_scheme_bit && isr_r[0] != `IMO_ZERO8)
        |=> !GROUP_REQUEST_O[0])
        else $error("rotating group requested past fence");
    a_poll_no_service: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && mode_r[1].poll_select_bit) |=> ((isr_r[1] & ~$past(isr_r[1])) == `IMO_ZERO8))
        else $error("in-service set in polled mode");
    a_group_one_wins: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && ack_rise && pick[0].found) |=> (VECTOR_VALID_O && !VECTOR_GRP_O))
        else $error("group two won over group one");
    a_mask_blocks_req: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && (pend_r[0] & ~mask_r[0]) == `IMO_ZERO8) |=> !GROUP_REQUEST_O[0])
        else $error("masked request reached group output");
    a_readback_mask: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && DP_RD_I && !DP_RD_GRP_I && mode_r[0].readback_select_high
         && !mode_r[0].readback_select_low) |=> (RD_DATA_O == $past(mask_r[0])))
        else $error("readback did not return mask");
    a_no_ack_no_vec: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        (CE_I && !ack_rise) |=> !VECTOR_VALID_O)
        else $error("vector without acknowledge");

endmodule

//--- dv/host_model.sv
// ==========================================
// Host side: acknowledges one request per bench ask
// ==========================================
module host_model
(
    input wire logic clk_i,        // Bus clock
    input wire logic irq_i,        // Bus interrupt request
    input wire logic valid_i,      // Vector strobe
    input wire logic [7:0] vec_i,  // Vector
    input wire logic grp_i,        // Winning group
    input wire logic [7:0] want_i, // Acknowledges asked so far
    input wire logic [7:0] slow_i, // Extra cycles before acknowledging
    output logic ack_o,            // Acknowledge strobe
    output logic [7:0] vec_o,      // Last vector taken
    output logic grp_o,            // Last group taken
    output logic [7:0] n_ack_o     // Acknowledges finished
);
    timeunit 1ns;
    timeprecision 1ps;

    // Strobe held until the vector strobe is seen or 4 cycles pass, then dropped for at least two cycles
    // so that every acknowledge starts from a fresh rising edge
    initial
    begin
        ack_o = 1'b0;
        n_ack_o = 8'h00;
        forever
        begin
            @(negedge clk_i);
            if (irq_i === 1'b1 && n_ack_o < want_i)
            begin
                repeat (slow_i) @(negedge clk_i);
                ack_o = 1'b1;
                for (int i = 0; i < 4 && valid_i !== 1'b1; i++) @(negedge clk_i);
                // Only a seen vector counts; a missing one makes the bench time out
                if (valid_i === 1'b1)
                begin
                    vec_o = vec_i;
                    grp_o = grp_i;
                    n_ack_o++;
                end
                ack_o = 1'b0;
                @(negedge clk_i);
            end
        end
    end
endmodule

//--- dv/tb_interrupt_mode_options.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_interrupt_mode_options
    import imo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Signals
    // ==========================================
    logic clk, rst_b, ce, jmp, dp_rd, dp_grp, ack, breq, vvalid, vgrp, hgrp;
    logic [15:0] pio;        // Parallel pins, idle high
    logic [3:0] ur;          // User reply pins, idle high
    host_cmd_t cmd;          // Host strobes
    logic [1:0] greq;        // Group requests
    logic [7:0] rd_data, vec_o, hvec, want, slow, n_ack;
    logic [7:0] vec_mem [16]; // Expected vector memory
    int seed = 33;
    int n_fail = 0;
    int samples_checked = 0;

    interrupt_mode_options interrupt_mode_options_inst (.CLK_I(clk), .RST_B_I(rst_b),
        .CE_I(ce), .PIO_I(pio), .USER_REPLY_I(ur), .SOURCE_SELECT_JUMPER_I(jmp),
        .HOST_CMD_I(cmd), .DP_RD_I(dp_rd), .DP_RD_GRP_I(dp_grp),
        .ACKNOWLEDGE_STROBE_I(ack), .GROUP_REQUEST_O(greq),
        .BUS_REQUEST_LEVEL_FOUR_O(breq), .RD_DATA_O(rd_data), .VECTOR_O(vec_o),
        .VECTOR_VALID_O(vvalid), .VECTOR_GRP_O(vgrp));
    host_model host_model_inst (.clk_i(clk), .irq_i(breq), .valid_i(vvalid), .vec_i(vec_o),
        .grp_i(vgrp), .want_i(want), .slow_i(slow), .ack_o(ack), .vec_o(hvec),
        .grp_o(hgrp), .n_ack_o(n_ack));

    // Free-running 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================
    // Tasks
    // ==========================================
    // Kind k: 0 mode, 1 mask, 2 auto-clear, 3 vector, 4 clear in-service, 5 clear pending
    task automatic send(input int k, input logic g, input logic [2:0] l, input logic [7:0] d);
        @(negedge clk) cmd = {6'h20 >> k, g, l, d};
        @(negedge clk) cmd = '0;
    endtask

    // Data port read, result lands one edge later
    task automatic rd(input logic g, input logic [7:0] e);
        @(negedge clk) dp_rd = 1'b1;
        dp_grp = g;
        @(negedge clk) dp_rd = 1'b0;
        `CHK(rd_data, e)
    endtask

    // Pins 0..15 parallel, 16..19 user reply; waits past the synchronisers
    task automatic pin(input int i, input logic v);
        @(negedge clk);
        if (i < 16) pio[i] = v;
        else ur[i - 16] = v;
        repeat (5) @(negedge clk);
    endtask

    task automatic pulse(input int i);
        pin(i, 1'b0);
        pin(i, 1'b1);
    endtask

    // Ask the host for one acknowledge; s means the common vector is expected
    task automatic take(input logic g, input logic [2:0] l, input logic s);
        slow = 8'({$random(seed)} % 4);
        want++;
        for (int i = 0; i < 60 && n_ack < want; i++) @(negedge clk);
        if (n_ack !== want)
        begin
            n_fail++;
            final_report();
        end
        else
        begin
            `CHK(hvec, vec_mem[s ? {g, 3'h0} : {g, l}])
            `CHK(hgrp, g)
        end
    endtask

    task automatic final_report();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // Main sequence; every mode write keeps bit 3 clear
    // ==========================================
    initial
    begin
        {rst_b, jmp, dp_rd, dp_grp, want, slow} = '0;
        {ce, pio, ur, cmd} = {1'b1, 16'hFFFF, 4'hF, 18'h0};
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        `CHK({greq, breq, vvalid}, 4'h0)
        send(0, 0, 0, 8'h40);
        rd(0, 8'hFF);
        rd(1, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            vec_mem[i] = 8'($random(seed));
            send(3, i[3], i[2:0], vec_mem[i]);
        end
        send(1, 0, 0, 8'h00);
        send(1, 1, 0, 8'h00);
        send(0, 0, 0, 8'h00);
        pulse(3);
        `CHK(greq, 2'h0)
        rd(0, 8'h08);
        pulse(8);
        pulse(5);
        // Arming through group two must arm group one too
        send(0, 1, 0, 8'h80);
        repeat (2) @(negedge clk);
        `CHK({greq, breq}, 3'h7)
        take(0, 3, 0);
        take(1, 0, 0);
        send(4, 0, 3, 8'h00);
        take(0, 5, 0);
        send(4, 0, 5, 8'h00);
        send(4, 1, 0, 8'h00);
        send(0, 0, 0, 8'h82);
        pulse(6);
        take(0, 6, 1);
        send(4, 0, 6, 8'h00);
        send(0, 0, 0, 8'h84);
        pulse(2);
        `CHK(greq, 2'h0)
        rd(0, 8'h04);
        send(0, 0, 0, 8'hA4);
        rd(0, 8'h00);
        send(5, 0, 2, 8'h00);
        send(2, 0, 0, 8'h5A);
        send(0, 0, 0, 8'hE4);
        rd(0, 8'h5A);
        rd(0, 8'h5A);
        send(0, 0, 0, 8'h90);
        pin(1, 1'b0);
        `CHK(greq, 2'h0)
        pin(1, 1'b1);
        take(0, 1, 0);
        jmp = 1'b1;
        pulse(12);
        `CHK(greq, 2'h0)
        pulse(16);
        take(1, 4, 0);
        // Rotation: line 1 was served last, so line 2 now leads
        send(2, 0, 0, 8'h00);
        // No in-service bit of group one stands when rotation is chosen
        send(0, 0, 0, 8'h91);
        pulse(0);
        pulse(4);
        take(0, 4, 0);
        pulse(5);
        `CHK(greq, 2'h0)
        send(4, 0, 4, 8'h00);
        take(0, 5, 0);
        send(4, 0, 5, 8'h00);
        take(0, 0, 0);
        send(4, 0, 0, 8'h00);
        rd(0, 8'h00);
        final_report();
    end
endmodule
